// ### bench/bmc_cfg_host.sv
// Configuration host model issuing one-cycle register requests
`timescale 1ns/10ps
module bmc_cfg_host
   import bmc_pkg::*;
(
   input wire logic clk,
   output bmc_cfg_req_t cfg_req,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_ack
);
   initial cfg_req = '0;
   // Idle fields inverted so stale values never look valid
   task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be,
                         input logic [31:0] dat, output logic [31:0] q, output logic k);
      @(posedge clk);
      cfg_req <= '{wr: w, rd: !w, addr: a, byte_en: be, wdata: dat};
      @(posedge clk);
      cfg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, byte_en: ~be, wdata: ~dat};
      #1;
      k = cfg_ack;
      q = cfg_rdata;
   endtask
endmodule

// ### bench/bmc_config_assertions.sv
// Port-level checks of the bridge configuration registers
`timescale 1ns/10ps
module bmc_config_assertions
   import bmc_pkg::*;
#(
   parameter int GPIO_WIDTH = 4,
   parameter int NUM_CLK_OUT = 10
)
(
   input wire logic clk,
   input wire logic rst,
   input wire bmc_cfg_req_t cfg_req,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_ack,
   input wire bmc_err_events_t err_events,
   input wire logic system_error_enable_bit,
   input wire logic primary_system_error_out_n,
   input wire logic [GPIO_WIDTH-1:0] gpio_in,
   input wire logic [GPIO_WIDTH-1:0] gpio_out,
   input wire logic [GPIO_WIDTH-1:0] gpio_oe,
   input wire logic [NUM_CLK_OUT-1:0] secondary_clock_outputs
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   logic w64;
   logic w68;
   logic [3:0] be;
   logic [31:0] d;
   assign be = cfg_req.byte_en;
   assign d = cfg_req.wdata;
   assign w64 = cfg_req.wr && cfg_req.addr == BMC_OFS_EVENT_GPIO;
   assign w68 = cfg_req.wr && cfg_req.addr == BMC_OFS_CLOCK_CTRL;
   a_ack_follows: assert property ((cfg_req.wr || cfg_req.rd) |=> cfg_ack)
      else $error("no ack after request");
   a_rsv_event: assert property (
      (cfg_ack && $past(cfg_req.rd) && $past(cfg_req.addr) == BMC_OFS_EVENT_GPIO)
      |-> (cfg_rdata[27:24] == 4'h0 && !cfg_rdata[7] && !cfg_rdata[0]))
      else $error("reserved event bits set");
   a_rsv_clock: assert property (
      (cfg_ack && $past(cfg_req.rd) && $past(cfg_req.addr) == BMC_OFS_CLOCK_CTRL)
      |-> cfg_rdata[31:14] == 18'h0)
      else $error("reserved clock bits set");
   a_serr_cause: assert property (!primary_system_error_out_n
      |-> $past(system_error_enable_bit) && $past(err_events) != 5'h0)
      else $error("error output without cause");
   a_pin_undriven: assert property ((gpio_out & ~gpio_oe) == '0)
      else $error("undriven pin shows data");
   a_pin_set: assert property (w64 && be[1] && d[12] && gpio_oe[0] && !be[2] |=> gpio_out[0])
      else $error("set did not drive high");
   a_pin_clear: assert property (w64 && be[1] && d[8] && !d[12] |=> !gpio_out[0])
      else $error("clear did not drive low");
   a_oe_clear: assert property (w64 && be[2] && d[16] && !d[20] |=> !gpio_oe[0])
      else $error("driver not released");
   a_oe_set: assert property (w64 && be[2] && d[20] |=> gpio_oe[0])
      else $error("driver not enabled");
   a_pin_steady: assert property (!w64 |=> $stable(gpio_oe) && $stable(gpio_out))
      else $error("pin changed without write");
   a_clk_half: assert property ((secondary_clock_outputs & $past(secondary_clock_outputs)) == '0)
      else $error("clock high too long");
   a_clk_stop: assert property (w68 && be[1:0] == 2'h3 && d[13:0] == 14'h3FFF
      |-> ##3 (secondary_clock_outputs == '0) [*4])
      else $error("clocks not stopped");
   c_serr: cover property (!primary_system_error_out_n);
   c_drive: cover property ($rose(gpio_oe[0]));
   c_all_stop: cover property (secondary_clock_outputs == '0 [*4]);
endmodule

// ### bench/testbench.sv
// Self-checking bench for the bridge configuration registers
`timescale 1ns/10ps
module testbench;
   import bmc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   bmc_cfg_req_t cfg_req;
   logic [31:0] cfg_rdata;
   logic cfg_ack;
   bmc_err_events_t err_events = '0;
   logic system_error_enable_bit = 1'b1;
   logic primary_system_error_out_n;
   logic [3:0] gpio_out, gpio_oe;
   logic [3:0] pin_ext = 4'hA;
   wire [3:0] pins = (gpio_oe & gpio_out) | (~gpio_oe & pin_ext);
   logic [9:0] clk_outs;
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [31:0] q;
   logic k;
   logic [7:0] m;
   int mbit[6] = '{1, 6, 2, 3, 4, 5};
   bmc_err_events_t evs[6] = '{5'h10, 5'h10, 5'h01, 5'h02, 5'h04, 5'h08};
   always #5 clk = ~clk;
   bmc_config_regs bmc_config_regs_inst (.clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
      .cfg_ack(cfg_ack), .err_events(err_events), .system_error_enable_bit(system_error_enable_bit),
      .primary_system_error_out_n(primary_system_error_out_n), .gpio_in(pins), .gpio_out(gpio_out),
      .gpio_oe(gpio_oe), .secondary_clock_outputs(clk_outs));
   bmc_cfg_host bmc_cfg_host_inst (.clk(clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] dat);
      bmc_cfg_host_inst.access(1'b1, a, be, dat, q, k);
      chk({31'h0, k}, 32'h1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bmc_cfg_host_inst.access(1'b0, a, 4'hF, 32'h0, q, k);
      chk(q, exp);
   endtask
   task automatic io(input logic [7:0] e);
      chk({24'h0, gpio_oe, gpio_out}, {24'h0, e});
   endtask
   task automatic pulse(input bmc_err_events_t ev, input logic e);
      @(posedge clk);
      err_events <= ev;
      @(posedge clk);
      err_events <= '0;
      #1;
      chk({31'h0, primary_system_error_out_n}, {31'h0, e});
   endtask
   // Running clocks toggle every sample; stopped ones sit low
   task automatic clkchk(input logic [9:0] t);
      logic [9:0] a;
      @(posedge clk);
      #1;
      a = clk_outs;
      @(posedge clk);
      #1;
      chk({12'h0, a ^ clk_outs, a & ~t}, {12'h0, t, 10'h0});
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      rd(BMC_OFS_LIMIT_HIGH, 32'h0);
      rd(BMC_OFS_EVENT_GPIO, 32'hA000_0000);
      rd(BMC_OFS_CLOCK_CTRL, 32'h0);
      wr(BMC_OFS_LIMIT_HIGH, 4'hF, 32'hFFFF_FFFF);
      wr(BMC_OFS_LIMIT_HIGH, 4'h5, 32'hA5A5_A5A5);
      rd(BMC_OFS_LIMIT_HIGH, 32'hFFA5_FFA5);
      wr(8'h60, 4'hF, 32'h1234_5678);
      rd(8'h60, 32'h0);
      rd(BMC_OFS_LIMIT_HIGH, 32'hFFA5_FFA5);
      wr(BMC_OFS_EVENT_GPIO, 4'h1, 32'hFF);
      rd(BMC_OFS_EVENT_GPIO, 32'hA000_007E);
      for (int i = 0; i < 6; i++) begin
         m = 8'h1 << mbit[i];
         wr(BMC_OFS_EVENT_GPIO, 4'h1, {24'h0, m});
         pulse(evs[i], 1'b1);
         wr(BMC_OFS_EVENT_GPIO, 4'h1, {24'h0, ~m & (evs[i][4] ? 8'h3C : 8'h7E)});
         pulse(evs[i], 1'b0);
      end
      wr(BMC_OFS_EVENT_GPIO, 4'h1, 32'h0);
      @(posedge clk);
      system_error_enable_bit <= 1'b0;
      pulse(5'h1F, 1'b1);
      @(posedge clk);
      system_error_enable_bit <= 1'b1;
      pulse(5'h1F, 1'b0);
      wr(BMC_OFS_EVENT_GPIO, 4'h6, 32'h0010_1000);
      io(8'h11);
      repeat (5) @(posedge clk);
      rd(BMC_OFS_EVENT_GPIO, 32'hB010_1000);
      wr(BMC_OFS_EVENT_GPIO, 4'h2, 32'h0000_0100);
      io(8'h10);
      wr(BMC_OFS_EVENT_GPIO, 4'h2, 32'h0000_3000);
      io(8'h11);
      wr(BMC_OFS_EVENT_GPIO, 4'h4, 32'h0020_0000);
      io(8'h33);
      wr(BMC_OFS_EVENT_GPIO, 4'h6, 32'h0);
      io(8'h33);
      wr(BMC_OFS_EVENT_GPIO, 4'h4, 32'h0001_0000);
      io(8'h22);
      @(posedge clk);
      pin_ext <= 4'h5;
      repeat (5) @(posedge clk);
      rd(BMC_OFS_EVENT_GPIO, 32'h7001_0000);
      wr(BMC_OFS_EVENT_GPIO, 4'h4, 32'h0002_0000);
      io(8'h00);
      wr(BMC_OFS_CLOCK_CTRL, 4'h3, 32'hFFFF_FFFF);
      repeat (6) @(posedge clk);
      clkchk(10'h000);
      rd(BMC_OFS_CLOCK_CTRL, 32'h3FFF);
      wr(BMC_OFS_CLOCK_CTRL, 4'h3, 32'h1555);
      repeat (4) @(posedge clk);
      clkchk(10'h2AF);
      wr(BMC_OFS_CLOCK_CTRL, 4'h3, 32'h0);
      repeat (4) @(posedge clk);
      clkchk(10'h3FF);
      end_of_test();
   end
endmodule
bind bmc_config_regs bmc_config_assertions #(.GPIO_WIDTH(GPIO_WIDTH), .NUM_CLK_OUT(NUM_CLK_OUT))
   bmc_config_assertions_inst (.clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
   .cfg_ack(cfg_ack), .err_events(err_events), .system_error_enable_bit(system_error_enable_bit),
   .primary_system_error_out_n(primary_system_error_out_n), .gpio_in(gpio_in), .gpio_out(gpio_out),
   .gpio_oe(gpio_oe), .secondary_clock_outputs(secondary_clock_outputs));

// ### src/bmc_clk_gate.sv
// One gated secondary clock output, divided from the PCI clock
`timescale 1ns/10ps
module bmc_clk_gate
   import bmc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   output logic clk_out
);

   // The enable is only looked at while the output is low, and a high
   // phase is always followed by a low one, so no short pulse can appear.
   always_ff @(posedge clk) begin
      if (rst) begin
         clk_out <= 1'b0;
      end else if (clk_out) begin
         clk_out <= 1'b0;
      end else begin
         clk_out <= run; // see RULE21
      end
   end

endmodule

// ### src/bmc_config_regs.sv
// Bridge configuration registers: window limit, error mask, GPIO port, clock gating
`timescale 1ns/10ps
module bmc_config_regs
   import bmc_pkg::*;
#(
   parameter int GPIO_WIDTH = 4,
   parameter int NUM_CLK_OUT = 10
)
(
   input wire logic clk,
   input wire logic rst,
   input wire bmc_cfg_req_t cfg_req,
   output logic [31:0] cfg_rdata,
   output logic cfg_ack,
   input wire bmc_err_events_t err_events,
   input wire logic system_error_enable_bit,
   output logic primary_system_error_out_n,
   input wire logic [GPIO_WIDTH-1:0] gpio_in,
   output logic [GPIO_WIDTH-1:0] gpio_out,
   output logic [GPIO_WIDTH-1:0] gpio_oe,
   output logic [NUM_CLK_OUT-1:0] secondary_clock_outputs
);

   // The register layout has room for exactly four pins and ten clocks
   if (GPIO_WIDTH != 4 || NUM_CLK_OUT != 10) begin : gen_bad_params
      $error("GPIO_WIDTH must be 4 and NUM_CLK_OUT must be 10");
   end

   logic [31:0] limit_high;
   logic [7:0] event_mask;
   logic [3:0] gpio_clr_last;
   logic [3:0] gpio_set_last;
   logic [3:0] gpio_oe_clr_last;
   logic [3:0] gpio_oe_set_last;
   logic [3:0] gpio_data;
   logic [3:0] gpio_dir;
   logic [3:0] gpio_sync1;
   logic [3:0] gpio_sync2;
   logic [3:0] gpio_sync3;
   logic [3:0] gpio_level;
   logic [15:0] clock_ctrl;
   logic [3:0] next_gpio_data;
   logic [3:0] next_gpio_dir;
   logic [NUM_CLK_OUT-1:0] clk_run;
   logic [31:0] clock_word;

   logic wr_limit;
   logic wr_event_gpio;
   logic wr_clock;

   assign wr_limit = cfg_req.wr && cfg_req.addr == BMC_OFS_LIMIT_HIGH;
   assign wr_event_gpio = cfg_req.wr && cfg_req.addr == BMC_OFS_EVENT_GPIO;
   assign wr_clock = cfg_req.wr && cfg_req.addr == BMC_OFS_CLOCK_CTRL;

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_word, input logic [31:0] new_word,
                                               input logic [3:0] byte_en);
      logic [31:0] result;
      result = old_word;
      for (int i = 0; i < 4; i++) begin
         if (byte_en[i]) begin
            result[i*8 +: 8] = new_word[i*8 +: 8];
         end
      end
      return result;
   endfunction

   // Whether a secondary clock is stopped by the gating register
   function automatic logic clock_stopped(input logic [15:0] ctrl, input int idx);
      logic stopped;
      if (idx < BMC_CLK_PAIRED) begin
         stopped = ctrl[2*idx] && ctrl[2*idx+1]; // see RULE17
      end else begin
         stopped = ctrl[BMC_CLK_SINGLE_LSB + idx - BMC_CLK_PAIRED]; // see RULE18
      end
      return stopped;
   endfunction

   // Upstream window limit, upper half
   always_ff @(posedge clk) begin
      if (rst) begin
         limit_high <= BMC_RST_LIMIT_HIGH; // see RULE1
      end else if (wr_limit) begin
         limit_high <= merge_bytes(limit_high, cfg_req.wdata, cfg_req.byte_en); // see RULE1
      end
   end

   // Error event mask; reserved bits never store a one
   always_ff @(posedge clk) begin
      if (rst) begin
         event_mask <= BMC_RST_EVENT_MASK;
      end else if (wr_event_gpio && cfg_req.byte_en[0]) begin
         event_mask <= cfg_req.wdata[7:0] & BMC_MASK_WRITABLE; // see RULE8
      end
   end

   // Error output: one low cycle for each cycle carrying an unmasked event while system_error_enable_bit is set
   always_ff @(posedge clk) begin
      if (rst) begin
         primary_system_error_out_n <= 1'b1;
      end else begin
         primary_system_error_out_n <= !(system_error_enable_bit && ( // see RULE2
            (err_events.rd_no_data && !event_mask[BMC_MASK_NO_DATA_A]
                                   && !event_mask[BMC_MASK_NO_DATA_B]) || // see RULE3
            (err_events.wr_nondeliv && !event_mask[BMC_MASK_WR_NONDELIV]) || // see RULE4
            (err_events.pw_target_abort && !event_mask[BMC_MASK_TGT_ABORT]) || // see RULE5
            (err_events.pw_master_abort && !event_mask[BMC_MASK_MST_ABORT]) || // see RULE6
            (err_events.dw_nondeliv && !event_mask[BMC_MASK_DW_NONDELIV]))); // see RULE7
      end
   end

   // Read-back copies of the write-1 fields: only an enabled byte lane updates them
   always_ff @(posedge clk) begin
      if (rst) begin
         gpio_clr_last <= BMC_RST_GPIO_FIELD; // see RULE13
         gpio_set_last <= BMC_RST_GPIO_FIELD;
         gpio_oe_clr_last <= BMC_RST_GPIO_FIELD;
         gpio_oe_set_last <= BMC_RST_GPIO_FIELD;
      end else if (wr_event_gpio) begin
         if (cfg_req.byte_en[1]) begin
            gpio_clr_last <= cfg_req.wdata[BMC_GPIO_CLR_LSB +: 4]; // see RULE13
            gpio_set_last <= cfg_req.wdata[BMC_GPIO_SET_LSB +: 4];
         end
         if (cfg_req.byte_en[2]) begin
            gpio_oe_clr_last <= cfg_req.wdata[BMC_GPIO_OE_CLR_LSB +: 4];
            gpio_oe_set_last <= cfg_req.wdata[BMC_GPIO_OE_SET_LSB +: 4];
         end
      end
   end

   // Data and direction state; a set and a clear of the same bit together: set wins
   always_comb begin
      next_gpio_data = gpio_data;
      next_gpio_dir = gpio_dir;
      if (wr_event_gpio && cfg_req.byte_en[1]) begin
         next_gpio_data = (gpio_data & ~cfg_req.wdata[BMC_GPIO_CLR_LSB +: 4]) // see RULE9
                        | cfg_req.wdata[BMC_GPIO_SET_LSB +: 4]; // see RULE10
      end
      if (wr_event_gpio && cfg_req.byte_en[2]) begin
         next_gpio_dir = (gpio_dir & ~cfg_req.wdata[BMC_GPIO_OE_CLR_LSB +: 4]) // see RULE14
                       | cfg_req.wdata[BMC_GPIO_OE_SET_LSB +: 4]; // see RULE15
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         gpio_data <= BMC_RST_GPIO_FIELD;
         gpio_dir <= BMC_RST_GPIO_FIELD;
      end else begin
         gpio_data <= next_gpio_data;
         gpio_dir <= next_gpio_dir;
      end
   end

   // Pins follow the edge that takes the write, so the level is there in the next cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         gpio_out <= BMC_RST_GPIO_FIELD;
         gpio_oe <= BMC_RST_GPIO_FIELD;
      end else begin
         gpio_oe <= next_gpio_dir; // see RULE11
         gpio_out <= next_gpio_data & next_gpio_dir; // see RULE12
      end
   end

   // Three-stage synchroniser; a level is accepted when stages two and three agree
   always_ff @(posedge clk) begin
      if (rst) begin
         gpio_sync1 <= BMC_RST_GPIO_FIELD;
         gpio_sync2 <= BMC_RST_GPIO_FIELD;
         gpio_sync3 <= BMC_RST_GPIO_FIELD;
      end else begin
         gpio_sync1 <= gpio_in; // see RULE20
         gpio_sync2 <= gpio_sync1;
         gpio_sync3 <= gpio_sync2;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         gpio_level <= BMC_RST_GPIO_FIELD;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (gpio_sync2[i] == gpio_sync3[i]) begin
               gpio_level[i] <= gpio_sync3[i]; // see RULE16
            end
         end
      end
   end

   // Clock gating register; reserved top bits never store a one
   assign clock_word = merge_bytes({16'h0000, clock_ctrl}, cfg_req.wdata, cfg_req.byte_en);

   always_ff @(posedge clk) begin
      if (rst) begin
         clock_ctrl <= BMC_RST_CLOCK_CTRL;
      end else if (wr_clock) begin
         clock_ctrl <= clock_word[15:0] & BMC_CLOCK_CTRL_WRITABLE; // see RULE19
      end
   end

   // Outputs run at half the PCI clock so that each one leaves a flip-flop
   generate
      for (genvar g = 0; g < NUM_CLK_OUT; g++) begin : gen_clk
         assign clk_run[g] = !clock_stopped(clock_ctrl, g); // see RULE17
         bmc_clk_gate u_gate (
            .clk(clk),
            .rst(rst),
            .run(clk_run[g]),
            .clk_out(secondary_clock_outputs[g])
         );
      end
   endgenerate

   // Read answer one cycle after the request; unmapped offsets return zero
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_rdata <= BMC_RDATA_RST;
         cfg_ack <= 1'b0;
      end else begin
         cfg_ack <= cfg_req.wr || cfg_req.rd;
         if (cfg_req.rd) begin
            unique case (cfg_req.addr)
               BMC_OFS_LIMIT_HIGH: begin
                  cfg_rdata <= limit_high;
               end
               BMC_OFS_EVENT_GPIO: begin
                  cfg_rdata <= {gpio_level, 4'h0, gpio_oe_set_last, gpio_oe_clr_last, // see RULE16
                                gpio_set_last, gpio_clr_last, event_mask}; // see RULE8
               end
               BMC_OFS_CLOCK_CTRL: begin
                  cfg_rdata <= {16'h0000, clock_ctrl}; // see RULE19
               end
               default: begin
                  cfg_rdata <= BMC_RDATA_RST;
               end
            endcase
         end else begin
            cfg_rdata <= BMC_RDATA_RST;
         end
      end
   end

endmodule

// ### src/bmc_pkg.sv
// Constants, field layouts and carrier types of the bridge configuration registers
// How it works
// RULE1 - 32-bit read/write upper limit of the upstream window, reset to zero.
// RULE2 - Error output asserts only for unmasked events with the system-error enable set.
// RULE3 - Mask bits 1 and 6 both gate the read no-data-from-target event.
// RULE4 - Mask bit 2 gates the write non-delivery event.
// RULE5 - Mask bit 3 gates target abort during posted write delivery.
// RULE6 - Mask bit 4 gates master abort during posted write delivery.
// RULE7 - Mask bit 5 gates the delayed write non-delivery event.
// RULE8 - Mask bits 0 and 7 are reserved, read zero.
// RULE9 - Writing 1 in the clear field drives that pin low when bidirectional.
// RULE10 - Writing 1 in the set field drives that pin high when bidirectional.
// RULE11 - New pin level appears the clock cycle after the write completes.
// RULE12 - Input-only pins are never driven by set or clear writes.
// RULE13 - Writing 0 does nothing; fields read back last written value; reset zero.
// RULE14 - Output-enable clear makes the pin input only, driver off.
// RULE15 - Output-enable set makes the pin bidirectional, driving held data.
// RULE16 - Input field shows synchronised pin levels; bits 27 to 24 read zero.
// RULE17 - Clocks 0 to 3 stop only when both bits of their pair are 1.
// RULE18 - Clocks 4 to 9 stop and hold low when their single bit is 1.
// RULE19 - Clock gating bits 15 and 14 read as zero.
// RULE20 - Input pins are synchronised before reaching the input field.
// RULE21 - Clocks start and stop only while low, never giving a short pulse.
package bmc_pkg;

   localparam logic [7:0] BMC_OFS_LIMIT_HIGH = 8'h58;
   localparam logic [7:0] BMC_OFS_EVENT_GPIO = 8'h64;
   localparam logic [7:0] BMC_OFS_CLOCK_CTRL = 8'h68;

   localparam logic [31:0] BMC_RST_LIMIT_HIGH = 32'h0000_0000;
   localparam logic [7:0] BMC_RST_EVENT_MASK = 8'h00;
   localparam logic [3:0] BMC_RST_GPIO_FIELD = 4'h0;
   localparam logic [15:0] BMC_RST_CLOCK_CTRL = 16'h0000;

   // Writable mask bits 6:1; bits 0 and 7 are reserved
   localparam logic [7:0] BMC_MASK_WRITABLE = 8'h7E;
   localparam int BMC_MASK_NO_DATA_A = 1;
   localparam int BMC_MASK_WR_NONDELIV = 2;
   localparam int BMC_MASK_TGT_ABORT = 3;
   localparam int BMC_MASK_MST_ABORT = 4;
   localparam int BMC_MASK_DW_NONDELIV = 5;
   localparam int BMC_MASK_NO_DATA_B = 6;

   // Field positions inside the word at the event/GPIO offset
   localparam int BMC_GPIO_CLR_LSB = 8;
   localparam int BMC_GPIO_SET_LSB = 12;
   localparam int BMC_GPIO_OE_CLR_LSB = 16;
   localparam int BMC_GPIO_OE_SET_LSB = 20;
   localparam int BMC_GPIO_IN_LSB = 28;

   // Clock gating layout
   localparam int BMC_CLK_PAIRED = 4;
   localparam int BMC_CLK_SINGLE_LSB = 8;
   localparam logic [15:0] BMC_CLOCK_CTRL_WRITABLE = 16'h3FFF;

   localparam logic [31:0] BMC_RDATA_RST = 32'h0000_0000;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [3:0] byte_en;
      logic [31:0] wdata;
   } bmc_cfg_req_t;

   typedef struct packed {
      logic rd_no_data;
      logic dw_nondeliv;
      logic pw_master_abort;
      logic pw_target_abort;
      logic wr_nondeliv;
   } bmc_err_events_t;

endpackage
